/* logic/ics_cfg_i2c.sv */
// two-wire configuration slave with its 16-bit register file
// Functional notes
// - straps at reset pick one of three ports
// - slave only, open drain, never frames
// - fast-mode up to 400 kbit/s
// - answers one of four strap-chosen addresses
// - data line changes only while clock low
// - first byte: address then direction bit
// - ninth clock acknowledges, receiver drives it
// - write: index, high byte, low byte
// - read: index, repeated start, two bytes
// - reset returns all registers to defaults
module ics_cfg_i2c (
   input  wire logic                    clk,       // system clock
   input  wire logic                    resetn,    // async reset, low
   input  wire logic                    linkClk,   // link sampling clock
   input  wire ics_pkg::ics_pins_t      busIn,     // scl and sda levels
   input  wire logic [1:0]              portStrap, // port select straps
   input  wire logic [1:0]              addrStrap, // address straps
   output logic                         sdaOut,    // sda drive value
   output logic                         sdaOeN,    // sda enable, low
   output logic [1:0]                   cfgPort,   // latched port choice
   output logic [ics_pkg::REG_COUNT-1:0]
                [ics_pkg::DATA_W-1:0]   cfgRegs    // register contents
);

   // ****************************************
   // state
   // ****************************************
   ics_pkg::ics_link_t lk_ff;
   ics_pkg::ics_link_t nxt_lk;
   ics_pkg::ics_core_t cr_ff;
   ics_pkg::ics_core_t nxt_cr;
   logic               rise;
   logic               fall;
   logic               startEv;
   logic               stopEv;
   logic               addrHit;
   logic               wrEv;
   logic               rdEv;
   logic               linkOn;

   function automatic logic [6:0] slaveAddr(input logic [1:0] sel);
      slaveAddr = {ics_pkg::ADDR_BASE[6:2], sel};
   endfunction

   assign sdaOut  = lk_ff.sdaO;
   assign sdaOeN  = lk_ff.sdaOeN;
   assign cfgPort = cr_ff.strap.portSel;
   assign cfgRegs = cr_ff.regs;

   // ****************************************
   // core domain: straps and register file
   // ****************************************
   assign wrEv = cr_ff.wrSync[2] != cr_ff.wrSync[1];
   assign rdEv = cr_ff.rdSync[2] != cr_ff.rdSync[1];

   always_comb begin
      nxt_cr = cr_ff;
      nxt_cr.strapSync = {cr_ff.strapSync[1:0], portStrap, addrStrap};
      // straps stay put long after release, so a late capture is safe
      if (cr_ff.waitCnt != ics_pkg::STRAP_WAIT) begin
         nxt_cr.waitCnt = cr_ff.waitCnt + ics_pkg::WAIT_STEP;
      end else if (!cr_ff.captured &&
                   cr_ff.strapSync[1] == cr_ff.strapSync[2]) begin
         nxt_cr.captured = 1'b1;
         nxt_cr.strap    = cr_ff.strapSync[2];
      end
      nxt_cr.i2cOn  = cr_ff.captured &&
                      cr_ff.strap.portSel == ics_pkg::PORT_I2C;
      nxt_cr.wrSync = {cr_ff.wrSync[1:0], lk_ff.wrTgl};
      nxt_cr.rdSync = {cr_ff.rdSync[1:0], lk_ff.rdTgl};
      // index and data are held by the link while its toggle travels
      if (wrEv) begin
         nxt_cr.regs[lk_ff.idx] = lk_ff.wrData;
      end
      if (rdEv) begin
         nxt_cr.rdHold = cr_ff.regs[lk_ff.idx];
         nxt_cr.ackTgl = ~cr_ff.ackTgl;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cr_ff      <= '0;
         cr_ff.regs <= {ics_pkg::REG_COUNT{ics_pkg::REG_RESET}};
      end else begin
         cr_ff <= nxt_cr;
      end
   end

   // ****************************************
   // link domain: bus engine
   // ****************************************
   assign rise    = !lk_ff.prev.scl && lk_ff.filt.scl;
   assign fall    = lk_ff.prev.scl && !lk_ff.filt.scl;
   assign startEv = lk_ff.filt.scl && lk_ff.prev.scl &&
                    lk_ff.prev.sda && !lk_ff.filt.sda;
   assign stopEv  = lk_ff.filt.scl && lk_ff.prev.scl &&
                    !lk_ff.prev.sda && lk_ff.filt.sda;
   // the strap copy is frozen before the link is enabled, so it
   // crosses without a handshake
   assign addrHit = lk_ff.sh[7:1] == slaveAddr(cr_ff.strap.addrSel);
   // enable counts once the second and third stages are both high
   assign linkOn  = lk_ff.enSync[2] && lk_ff.enSync[1];

   always_comb begin
      nxt_lk = lk_ff;
      nxt_lk.sclSync = {lk_ff.sclSync[1:0], busIn.scl};
      nxt_lk.sdaSync = {lk_ff.sdaSync[1:0], busIn.sda};
      // a level counts once the two later stages agree
      if (lk_ff.sclSync[1] == lk_ff.sclSync[2]) begin
         nxt_lk.filt.scl = lk_ff.sclSync[2];
      end
      if (lk_ff.sdaSync[1] == lk_ff.sdaSync[2]) begin
         nxt_lk.filt.sda = lk_ff.sdaSync[2];
      end
      nxt_lk.prev    = lk_ff.filt;
      nxt_lk.enSync  = {lk_ff.enSync[1:0], cr_ff.i2cOn};
      nxt_lk.ackSync = {lk_ff.ackSync[1:0], cr_ff.ackTgl};
      if (lk_ff.ackSync[2] != lk_ff.ackSync[1]) begin
         nxt_lk.rdData = cr_ff.rdHold;
      end
      nxt_lk.sdaO = 1'b0;
      if (!linkOn) begin
         nxt_lk.st     = ics_pkg::ST_IDLE;
         nxt_lk.sdaOeN = 1'b1;
      end else if (startEv) begin
         nxt_lk.st     = ics_pkg::ST_ADDR;
         nxt_lk.cnt    = '0;
         nxt_lk.sdaOeN = 1'b1;
      end else if (stopEv) begin
         nxt_lk.st     = ics_pkg::ST_IDLE;
         nxt_lk.sdaOeN = 1'b1;
      end else begin
         case (lk_ff.st)
            ics_pkg::ST_ADDR, ics_pkg::ST_IDX, ics_pkg::ST_WDATA: begin
               if (rise) begin
                  nxt_lk.sh  = {lk_ff.sh[6:0], lk_ff.filt.sda};
                  nxt_lk.cnt = lk_ff.cnt + ics_pkg::BIT_STEP;
               end else if (fall && lk_ff.cnt == ics_pkg::BIT_LAST) begin
                  nxt_lk.cnt    = '0;
                  nxt_lk.sdaOeN = 1'b0;
                  case (lk_ff.st)
                     ics_pkg::ST_ADDR: begin
                        nxt_lk.rw = lk_ff.sh[0];
                        nxt_lk.st = ics_pkg::ST_AACK;
                        if (!addrHit) begin
                           nxt_lk.st     = ics_pkg::ST_IDLE;
                           nxt_lk.sdaOeN = 1'b1;
                        end
                     end
                     ics_pkg::ST_IDX: begin
                        nxt_lk.idx   = lk_ff.sh;
                        nxt_lk.rdTgl = ~lk_ff.rdTgl;
                        nxt_lk.st    = ics_pkg::ST_IACK;
                     end
                     default: begin
                        nxt_lk.st = ics_pkg::ST_WACK;
                        if (lk_ff.hiByte) begin
                           nxt_lk.wrData[15:8] = lk_ff.sh;
                        end else begin
                           nxt_lk.wrData[7:0] = lk_ff.sh;
                           nxt_lk.wrTgl       = ~lk_ff.wrTgl;
                        end
                     end
                  endcase
               end
            end
            ics_pkg::ST_AACK, ics_pkg::ST_IACK, ics_pkg::ST_WACK: begin
               if (fall) begin
                  nxt_lk.sdaOeN = 1'b1;
                  nxt_lk.hiByte = 1'b1;
                  case (lk_ff.st)
                     ics_pkg::ST_AACK: begin
                        if (lk_ff.rw) begin
                           nxt_lk.st     = ics_pkg::ST_RDATA;
                           nxt_lk.sh     = lk_ff.rdData[15:8];
                           nxt_lk.sdaOeN = lk_ff.rdData[15];
                        end else begin
                           nxt_lk.st = ics_pkg::ST_IDX;
                        end
                     end
                     ics_pkg::ST_IACK: begin
                        nxt_lk.st = ics_pkg::ST_WDATA;
                     end
                     default: begin
                        // bytes past the low byte are left unanswered
                        nxt_lk.hiByte = 1'b0;
                        nxt_lk.st     = lk_ff.hiByte ? ics_pkg::ST_WDATA
                                                     : ics_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
            ics_pkg::ST_RDATA: begin
               if (rise) begin
                  nxt_lk.cnt = lk_ff.cnt + ics_pkg::BIT_STEP;
               end else if (fall) begin
                  if (lk_ff.cnt == ics_pkg::BIT_LAST) begin
                     nxt_lk.cnt    = '0;
                     nxt_lk.sdaOeN = 1'b1;
                     nxt_lk.st     = ics_pkg::ST_RACK;
                  end else begin
                     nxt_lk.sh     = {lk_ff.sh[6:0], 1'b0};
                     nxt_lk.sdaOeN = lk_ff.sh[6];
                  end
               end
            end
            ics_pkg::ST_RACK: begin
               if (rise) begin
                  nxt_lk.mAck = !lk_ff.filt.sda;
               end else if (fall) begin
                  if (lk_ff.mAck && lk_ff.hiByte) begin
                     nxt_lk.st     = ics_pkg::ST_RDATA;
                     nxt_lk.hiByte = 1'b0;
                     nxt_lk.sh     = lk_ff.rdData[7:0];
                     nxt_lk.sdaOeN = lk_ff.rdData[7];
                  end else begin
                     nxt_lk.st = ics_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               nxt_lk.sdaOeN = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge linkClk or negedge resetn) begin
      if (!resetn) begin
         lk_ff        <= '0;
         lk_ff.sdaOeN <= 1'b1;
         // idle bus levels, so no false edge follows reset
         lk_ff.sclSync <= '1;
         lk_ff.sdaSync <= '1;
         lk_ff.filt    <= '1;
         lk_ff.prev    <= '1;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_addrEnd;
      lk_ff.st == ics_pkg::ST_ADDR && fall &&
      lk_ff.cnt == ics_pkg::BIT_LAST;
   endsequence

   sequence s_readEnd;
      lk_ff.st == ics_pkg::ST_RACK && fall && !lk_ff.mAck;
   endsequence

   property p_strapHold;
      @(posedge clk) disable iff (!resetn)
      cr_ff.captured |=> $stable(cr_ff.strap) && cr_ff.captured;
   endproperty
   a_strapHold: assert property (p_strapHold)
      else $error("strap choice changed after capture");

   property p_onlyLow;
      @(posedge linkClk) disable iff (!resetn)
      !lk_ff.sdaO && (lk_ff.st != ics_pkg::ST_IDLE || lk_ff.sdaOeN);
   endproperty
   a_onlyLow: assert property (p_onlyLow)
      else $error("sda driven high or held while idle");

   property p_driveInLow;
      @(posedge linkClk) disable iff (!resetn)
      $changed(lk_ff.sdaOeN) |-> !lk_ff.prev.scl;
   endproperty
   a_driveInLow: assert property (p_driveInLow)
      else $error("sda drive changed while scl high");

   property p_addrAck;
      @(posedge linkClk) disable iff (!resetn)
      s_addrEnd ##0 (addrHit && !startEv && !stopEv && linkOn)
      |=> !lk_ff.sdaOeN && lk_ff.st == ics_pkg::ST_AACK;
   endproperty
   a_addrAck: assert property (p_addrAck)
      else $error("matched address not acknowledged");

   property p_addrMiss;
      @(posedge linkClk) disable iff (!resetn)
      s_addrEnd ##0 !addrHit
      |=> lk_ff.sdaOeN && lk_ff.st == ics_pkg::ST_IDLE;
   endproperty
   a_addrMiss: assert property (p_addrMiss)
      else $error("foreign address answered");

   property p_nackEnd;
      @(posedge linkClk) disable iff (!resetn)
      s_readEnd ##0 (!startEv && !stopEv && linkOn)
      |=> lk_ff.st == ics_pkg::ST_IDLE ##1 lk_ff.sdaOeN [*2];
   endproperty
   a_nackEnd: assert property (p_nackEnd)
      else $error("bus kept after master nack");

   property p_regWrite;
      @(posedge clk) disable iff (!resetn)
      wrEv |=> cr_ff.regs[$past(lk_ff.idx)] == $past(lk_ff.wrData);
   endproperty
   a_regWrite: assert property (p_regWrite)
      else $error("register not updated by write");

   property p_regRead;
      @(posedge clk) disable iff (!resetn)
      rdEv |=> cr_ff.ackTgl != $past(cr_ff.ackTgl) &&
               cr_ff.rdHold == $past(cr_ff.regs[lk_ff.idx]);
   endproperty
   a_regRead: assert property (p_regRead)
      else $error("read data not captured");

   property p_addrPick;
      @(posedge linkClk) disable iff (!resetn)
      lk_ff.st == ics_pkg::ST_AACK |->
      $past(lk_ff.sh[7:1]) == slaveAddr(cr_ff.strap.addrSel);
   endproperty
   a_addrPick: assert property (p_addrPick)
      else $error("acknowledged wrong address");

endmodule

/* logic/ics_pkg.sv */
// constants and types shared by the configuration two-wire slave
package ics_pkg;

   // ****************************************
   // sizes and counts
   // ****************************************
   localparam int         REG_COUNT  = 256;
   localparam int         IDX_W      = 8;
   localparam int         DATA_W     = 16;
   localparam logic [3:0] BIT_LAST   = 4'h8;
   localparam logic [3:0] BIT_STEP   = 4'h1;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [1:0] WAIT_STEP  = 2'h1;

   // ****************************************
   // strap encodings and defaults
   // ****************************************
   localparam logic [1:0]        PORT_I2C  = 2'h0;
   localparam logic [1:0]        PORT_SPI  = 2'h1;
   localparam logic [1:0]        PORT_UART = 2'h2;
   // arbitrary base, the two low bits come from the address straps
   localparam logic [6:0]        ADDR_BASE = 7'h28;
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_ADDR  = 4'h1,
      ST_AACK  = 4'h2,
      ST_IDX   = 4'h3,
      ST_IACK  = 4'h4,
      ST_WDATA = 4'h5,
      ST_WACK  = 4'h6,
      ST_RDATA = 4'h7,
      ST_RACK  = 4'h8
   } ics_state_t;

   typedef struct packed {
      logic [1:0] portSel;
      logic [1:0] addrSel;
   } ics_strap_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } ics_pins_t;

   // link-side state, clocked by the link sampling clock
   typedef struct packed {
      logic [2:0]        sclSync;
      logic [2:0]        sdaSync;
      ics_pins_t         filt;
      ics_pins_t         prev;
      logic [2:0]        enSync;
      logic [2:0]        ackSync;
      ics_state_t        st;
      logic [3:0]        cnt;
      logic [7:0]        sh;
      logic              rw;
      logic              hiByte;
      logic              mAck;
      logic [IDX_W-1:0]  idx;
      logic [DATA_W-1:0] wrData;
      logic [DATA_W-1:0] rdData;
      logic              wrTgl;
      logic              rdTgl;
      logic              sdaO;
      logic              sdaOeN;
   } ics_link_t;

   // core-side state, clocked by the system clock
   typedef struct packed {
      logic [2:0][3:0]                     strapSync;
      logic [1:0]                          waitCnt;
      logic                                captured;
      ics_strap_t                          strap;
      logic                                i2cOn;
      logic [2:0]                          wrSync;
      logic [2:0]                          rdSync;
      logic [DATA_W-1:0]                   rdHold;
      logic                                ackTgl;
      logic [REG_COUNT-1:0][DATA_W-1:0]    regs;
   } ics_core_t;

endpackage

/* testbench/ics_cfg_i2c_bench.sv */
// self-checking bench for the two-wire configuration slave
`define CHK(nm, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got); \
   end \
end
module ics_cfg_i2c_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk, resetn, linkClk, resEv;
   logic [1:0]          portStrap, addrStrap, cfgPort;
   logic                sdaOut, sdaOeN, hostScl, hostSda, sdaW;
   logic [ics_pkg::REG_COUNT-1:0][ics_pkg::DATA_W-1:0] cfgRegs;
   logic [19:0]         res, want;
   ics_pkg::ics_pins_t  busIn;
   logic [19:0]         notes[$];
   int                  mismatches, comparisons, seed;

   // open drain with pull-up on data; clock driven by the master only
   assign sdaW = ~((~sdaOeN & ~sdaOut) | ~hostSda);
   assign busIn.scl = hostScl;
   assign busIn.sda = sdaW;

   ics_cfg_i2c ics_cfg_i2c_i (
      .clk       (clk),
      .resetn    (resetn),
      .linkClk   (linkClk),
      .busIn     (busIn),
      .portStrap (portStrap),
      .addrStrap (addrStrap),
      .sdaOut    (sdaOut),
      .sdaOeN    (sdaOeN),
      .cfgPort   (cfgPort),
      .cfgRegs   (cfgRegs)
   );
   ics_host_model ics_host_model_i (
      .sdaW   (sdaW),
      .sclOeN (hostScl),
      .sdaOeN (hostSda),
      .res    (res),
      .resEv  (resEv)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      linkClk = 1'b0;
      #3.3;
      forever #7.5 linkClk = ~linkClk;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // straps stay put well past release so capture sees them settled
   task automatic doReset(input logic [1:0] p, input logic [1:0] a);
      @(posedge clk);
      resetn <= 1'b0;
      portStrap <= p;
      addrStrap <= a;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (40) @(posedge clk);
   endtask

   // ****************************************
   // monitor: each finished frame is matched with the oldest note
   // ****************************************
   always @(resEv) begin
      if ($time > 0) begin
         if (notes.size() == 0) begin
            mismatches++;
            $display("unexpected frame: expected none seen %0h", res);
         end else begin
            want = notes.pop_front();
            `CHK("frame", want, res)
         end
      end
   end

   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      $display("unexpected watchdog: expected done seen hang");
      close_out();
   end

   initial begin
      logic [1:0]  p;
      logic [6:0]  dev;
      logic [7:0]  idx, prevIdx;
      logic [15:0] data;
      logic        en;
      resetn = 1'b0;
      portStrap = 2'h0;
      addrStrap = 2'h0;
      mismatches = 0;
      comparisons = 0;
      seed = 10191;
      prevIdx = 8'h00;
      // four addresses on the two-wire port, then the other two ports
      for (int k = 0; k < 6; k++) begin
         p = (k < 4) ? ics_pkg::PORT_I2C :
             ((k == 4) ? ics_pkg::PORT_SPI : ics_pkg::PORT_UART);
         doReset(p, 2'(k));
         en = (p === ics_pkg::PORT_I2C);
         dev = {ics_pkg::ADDR_BASE[6:2], 2'(k)};
         idx = 8'($random(seed));
         data = 16'($random(seed));
         `CHK("port", p, cfgPort)
         `CHK("idle sda", 1'b1, sdaOeN)
         `CHK("reg after reset", ics_pkg::REG_RESET, cfgRegs[prevIdx])
         notes.push_back({4'hF, 16'h0000});
         // odd tests miss in the base bits, even ones in a strap bit
         ics_host_model_i.xfer(dev ^ (k[0] ? 7'h40 : 7'h02), idx, 1'b0,
                               ~data);
         notes.push_back({en ? 4'h0 : 4'hF, 16'h0000});
         ics_host_model_i.xfer(dev, idx, 1'b0, data);
         notes.push_back(en ? {4'h0, data} : {4'hE, 16'hFFFF});
         ics_host_model_i.xfer(dev, idx, 1'b1, 16'h0000);
         `CHK("reg", en ? data : ics_pkg::REG_RESET, cfgRegs[idx])
         prevIdx = idx;
         $display("test %0d done", k);
      end
      #1;
      close_out();
   end
endmodule

/* testbench/ics_host_model.sv */
// two-wire bus master model standing on the far side of the slave
module ics_host_model (
   input  wire logic        sdaW,   // resolved data line
   output logic             sclOeN, // clock pulled low when 0
   output logic             sdaOeN, // data pulled low when 0
   output logic [19:0]      res,    // acks and read data of last frame
   output logic             resEv   // toggles when res is new
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // bit timing: 2500 ns period, exactly the top rate
   // ****************************************
   localparam int Q = 625;

   initial begin
      sclOeN = 1'b1;
      sdaOeN = 1'b1;
      res    = 20'h00000;
      resEv  = 1'b0;
   end

   // data moves mid-low, sampled late in high where the slave is settled
   task automatic bitx(input logic b, output logic r);
      #Q sdaOeN = b;
      #Q sclOeN = 1'b1;
      #1000 r = sdaW;
      #250 sclOeN = 1'b0;
   endtask

   // serves as start and repeated start alike
   task automatic startCond();
      #Q sdaOeN = 1'b1;
      #Q sclOeN = 1'b1;
      #1250 sdaOeN = 1'b0;
      #1250 sclOeN = 1'b0;
   endtask

   task automatic stopCond();
      #Q sdaOeN = 1'b0;
      #Q sclOeN = 1'b1;
      #1250 sdaOeN = 1'b1;
      #1250;
   endtask

   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic r;
      for (int n = 7; n >= 0; n--) bitx(b[n], r);
      bitx(1'b1, ack);
   endtask

   task automatic getByte(input logic nack, output logic [7:0] b);
      logic r;
      for (int n = 7; n >= 0; n--) bitx(1'b1, b[n]);
      bitx(nack, r);
   endtask

   task automatic xfer(input logic [6:0] a, input logic [7:0] i,
                       input logic rd, input logic [15:0] d);
      logic [3:0]  ack;
      logic [15:0] q;
      ack = 4'h0;
      q = 16'h0000;
      startCond();
      sendByte({a, 1'b0}, ack[3]);
      sendByte(i, ack[2]);
      if (rd) begin
         startCond();
         sendByte({a, 1'b1}, ack[1]);
         getByte(1'b0, q[15:8]);
         getByte(1'b1, q[7:0]);
      end else begin
         sendByte(d[15:8], ack[1]);
         sendByte(d[7:0], ack[0]);
      end
      stopCond();
      res = {ack, q};
      resEv = ~resEv;
   endtask
endmodule
